// ===== mpaf_port_mux.sv
// Port 1 and port 3 alternate-function routing with three timer/counters and an APB slave.
// Assumes pad inputs are asynchronous; core strobes and internal interrupts share pclk.
`timescale 1ns/10ps

module mpaf_port_mux (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [mpaf_pkg::ADDR_W-1:0]      paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic [7:0]                       p1_in,
    input  wire logic [7:0]                       p3_in,
    output logic      [7:0]                       p1_out,
    output logic      [7:0]                       p1_oe,
    output logic      [7:0]                       p3_out,
    output logic      [7:0]                       p3_oe,
    output logic                                  p1_pullup_en,
    output logic                                  p3_pullup_en,
    input  wire logic                             external_irq_in_n,
    input  wire logic                             internal_irq_src,
    input  wire logic                             core_rd_strobe_n,
    input  wire logic                             core_wr_strobe_n,
    output logic                                  shared_core_irq,
    output logic                                  dedicated_pin_irq,
    output logic                                  mem_rd_strobe_n,
    output logic                                  mem_wr_strobe_n
);

    localparam int P3_B2 = mpaf_pkg::PIN_P3 + 2;
    localparam int P3_B3 = mpaf_pkg::PIN_P3 + 3;
    localparam int P3_B6 = mpaf_pkg::PIN_P3 + 6;
    localparam int P3_B7 = mpaf_pkg::PIN_P3 + 7;

    // Pins on which a general-purpose input can be used without upsetting an alternate unit.
    function automatic logic [15:0] input_free(input logic [mpaf_pkg::TCTL_W-1:0] tc);
        logic [7:0] p1f;
        logic [7:0] p3f;
        p1f    = 8'hff;
        p3f    = 8'h3b;                 // Bits 2, 6 and 7 are never free inputs.
        p1f[0] = !tc[mpaf_pkg::TCTL_CSEL+2] || !tc[mpaf_pkg::TCTL_IE+2];
        p1f[1] = !tc[mpaf_pkg::TCTL_T2TRIG];
        p3f[4] = !tc[mpaf_pkg::TCTL_CSEL+0] || !tc[mpaf_pkg::TCTL_IE+0];
        p3f[5] = !tc[mpaf_pkg::TCTL_CSEL+1] || !tc[mpaf_pkg::TCTL_IE+1];
        return {p3f, p1f};
    endfunction

    // Pad synchronisers and falling-edge detection.
    logic [mpaf_pkg::PIN_W-1:0] sync1;
    logic [mpaf_pkg::PIN_W-1:0] sync2;
    logic [mpaf_pkg::PIN_W-1:0] prev;
    logic [mpaf_pkg::PIN_W-1:0] fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '1;
            sync2 <= '1;
            prev  <= '1;
        end else begin
            sync1 <= {external_irq_in_n, p3_in, p1_in};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    assign fall = prev & ~sync2;

    // Machine-cycle divider.
    logic [3:0] mc_cnt;
    logic [3:0] next_mc_cnt;
    logic       tick;

    always_comb begin
        tick        = (mc_cnt == mpaf_pkg::MC_LAST);
        next_mc_cnt = tick ? 4'h0 : mc_cnt + 4'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_cnt <= 4'h0;
        end else begin
            mc_cnt <= next_mc_cnt;
        end
    end

    // Software registers.
    logic [7:0]                  p1_latch;
    logic [7:0]                  p3_latch;
    logic [mpaf_pkg::GLOB_W-1:0] glob;
    logic [mpaf_pkg::TCTL_W-1:0] tctl;
    logic [mpaf_pkg::TMR_W-1:0]  t2_reload;
    logic [7:0]                  next_p1_latch;
    logic [7:0]                  next_p3_latch;
    logic [mpaf_pkg::GLOB_W-1:0] next_glob;
    logic [mpaf_pkg::TCTL_W-1:0] next_tctl;
    logic [mpaf_pkg::TMR_W-1:0]  next_t2_reload;
    logic                        wr_acc;
    logic                        ext_mode;

    assign wr_acc   = psel && penable && pready && pwrite;
    assign ext_mode = glob[mpaf_pkg::GLOB_EXT_MCU];

    always_comb begin
        next_p1_latch  = p1_latch;
        next_p3_latch  = p3_latch;
        next_glob      = glob;
        next_tctl      = tctl;
        next_t2_reload = t2_reload;
        if (wr_acc) begin
            unique case (paddr)
                mpaf_pkg::OFF_P1_LATCH:  next_p1_latch  = pwdata[7:0];
                // Strobe pins ignore latch writes so software cannot block a strobe.
                mpaf_pkg::OFF_P3_LATCH:  next_p3_latch  = {2'b11, pwdata[5:0]};
                mpaf_pkg::OFF_GLOB:      next_glob      = pwdata[mpaf_pkg::GLOB_W-1:0];
                mpaf_pkg::OFF_TCTL:      next_tctl      = pwdata[mpaf_pkg::TCTL_W-1:0];
                mpaf_pkg::OFF_T2_RELOAD: next_t2_reload = pwdata[mpaf_pkg::TMR_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p1_latch  <= mpaf_pkg::RST_LATCH;
            p3_latch  <= mpaf_pkg::RST_LATCH;
            glob      <= mpaf_pkg::RST_GLOB;
            tctl      <= mpaf_pkg::RST_TCTL;
            t2_reload <= '0;
        end else begin
            p1_latch  <= next_p1_latch;
            p3_latch  <= next_p3_latch;
            glob      <= next_glob;
            tctl      <= next_tctl;
            t2_reload <= next_t2_reload;
        end
    end

    // Timers.
    logic [mpaf_pkg::TMR_W-1:0] tmr_count [mpaf_pkg::NUM_TMR];
    logic [mpaf_pkg::TMR_W-1:0] t2_capture;
    logic [mpaf_pkg::NUM_TMR-1:0] tmr_event;

    assign tmr_event = {fall[mpaf_pkg::PIN_P1], fall[P3_B3+2], fall[P3_B3+1]};

    for (genvar i = 0; i < mpaf_pkg::NUM_TMR; i++) begin : g_tmr
        mpaf_pkg::mpaf_tmr_cfg_s cfg;
        logic [mpaf_pkg::TMR_W-1:0] cap;
        always_comb begin
            cfg.counter_mode = tctl[mpaf_pkg::TCTL_CSEL+i];
            cfg.run          = tctl[mpaf_pkg::TCTL_RUN+i];
            cfg.gate_en      = (i == 1) && tctl[mpaf_pkg::TCTL_T1GATE];
            cfg.trig_en      = (i == 2) && tctl[mpaf_pkg::TCTL_T2TRIG];
        end
        mpaf_timer u_tmr (
            .pclk       (pclk),
            .presetn    (presetn),
            .cfg        (cfg),
            .tick       (tick),
            .event_fall (tmr_event[i]),
            .gate_level (sync2[P3_B3]),
            .trig_fall  (fall[mpaf_pkg::PIN_P1+1]),
            .load_en    (wr_acc &&
                         paddr == 8'(mpaf_pkg::OFF_TMR0 + 8'(i) * mpaf_pkg::OFF_TMR_STEP)),
            .load_val   (pwdata[mpaf_pkg::TMR_W-1:0]),
            .reload_val (t2_reload),
            .count      (tmr_count[i]),
            .capture    (cap)
        );
        if (i == 2) begin : g_cap
            assign t2_capture = cap;
        end
    end

    // Pad outputs, driver enables and interrupt lines.
    logic [7:0] p3_alt;
    logic [7:0] next_p3_do;
    logic [7:0] p1_d1;
    logic [7:0] p3_d1;
    logic       next_shared;

    always_comb begin
        p3_alt = 8'hff;
        if (!ext_mode) begin
            p3_alt[6] = core_wr_strobe_n;
            p3_alt[7] = core_rd_strobe_n;
        end
        next_p3_do  = p3_latch & p3_alt;
        next_shared = internal_irq_src || !sync2[P3_B2] ||
                      (glob[mpaf_pkg::GLOB_XIRQ_EN] && !sync2[mpaf_pkg::PIN_XIRQ]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p1_out            <= mpaf_pkg::RST_LATCH;
            p3_out            <= mpaf_pkg::RST_LATCH;
            p1_d1             <= mpaf_pkg::RST_LATCH;
            p3_d1             <= mpaf_pkg::RST_LATCH;
            p1_oe             <= 8'h00;
            p3_oe             <= 8'h00;
            p1_pullup_en      <= 1'b1;
            p3_pullup_en      <= 1'b1;
            shared_core_irq   <= 1'b0;
            dedicated_pin_irq <= 1'b0;
            mem_rd_strobe_n   <= 1'b1;
            mem_wr_strobe_n   <= 1'b1;
        end else begin
            p1_out <= p1_latch;
            p3_out <= next_p3_do;
            p1_d1  <= p1_out;
            p3_d1  <= p3_out;
            // Enable is registered, so it is formed from next data and the one-clock copy.
            p1_oe  <= ~(p1_latch & p1_d1);
            p3_oe  <= ~(next_p3_do & p3_d1);
            p1_pullup_en      <= !glob[mpaf_pkg::GLOB_P1_PU_DIS];
            p3_pullup_en      <= !glob[mpaf_pkg::GLOB_P3_PU_DIS];
            shared_core_irq   <= next_shared;
            dedicated_pin_irq <= !sync2[P3_B3];
            mem_rd_strobe_n   <= ext_mode ? sync2[P3_B7] : core_rd_strobe_n;
            mem_wr_strobe_n   <= ext_mode ? sync2[P3_B6] : core_wr_strobe_n;
        end
    end

    // APB slave: zero wait states, error on unmapped addresses.
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        setup;

    always_comb begin
        setup        = psel && !penable;
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        unique case (paddr)
            mpaf_pkg::OFF_P1_LATCH:  next_prdata[7:0] = p1_latch;
            mpaf_pkg::OFF_P3_LATCH:  next_prdata[7:0] = p3_latch;
            mpaf_pkg::OFF_GLOB:      next_prdata[mpaf_pkg::GLOB_W-1:0] = glob;
            mpaf_pkg::OFF_TCTL:      next_prdata[mpaf_pkg::TCTL_W-1:0] = tctl;
            mpaf_pkg::OFF_PADS:      next_prdata = {input_free(tctl),
                                                    sync2[mpaf_pkg::PIN_P3 +: 8],
                                                    sync2[mpaf_pkg::PIN_P1 +: 8]};
            8'h14:                   next_prdata[mpaf_pkg::TMR_W-1:0] = tmr_count[0];
            8'h18:                   next_prdata[mpaf_pkg::TMR_W-1:0] = tmr_count[1];
            8'h1c:                   next_prdata[mpaf_pkg::TMR_W-1:0] = tmr_count[2];
            mpaf_pkg::OFF_T2_CAP:    next_prdata[mpaf_pkg::TMR_W-1:0] = t2_capture;
            mpaf_pkg::OFF_T2_RELOAD: next_prdata[mpaf_pkg::TMR_W-1:0] = t2_reload;
            mpaf_pkg::OFF_IRQ:       next_prdata[1:0] = {dedicated_pin_irq, shared_core_irq};
            default:                 next_pslverr = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            prdata  <= setup && !pwrite ? next_prdata : 32'h0000_0000;
            pslverr <= setup && next_pslverr;
        end
    end

    chk_oe_two_clock: assert property (@(posedge pclk) disable iff (!presetn)
        p3_oe == ~(p3_out & $past(p3_out, 2)))
        else $error("port 3 driver enable does not follow data and its two-clock copy");

    chk_p3_and_latch: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 p3_out[5:0] == $past(p3_latch[5:0]))
        else $error("port 3 general bits do not follow the latch");

    chk_p1_latch_only: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 p1_out == $past(p1_latch))
        else $error("port 1 output not taken from the latch");

    chk_int_strobes: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_mode |=> (p3_out[6] == $past(core_wr_strobe_n) &&
                       p3_out[7] == $past(core_rd_strobe_n)))
        else $error("core strobes not driven on port 3 bits 6 and 7");

    chk_ext_strobes: assert property (@(posedge pclk) disable iff (!presetn)
        ext_mode |=> (mem_rd_strobe_n == $past(sync2[P3_B7]) && p3_out[7:6] == 2'b11))
        else $error("emulator read strobe not taken from port 3 bit 7");

    chk_shared_merge: assert property (@(posedge pclk) disable iff (!presetn)
        (internal_irq_src || (glob[mpaf_pkg::GLOB_XIRQ_EN] && !sync2[mpaf_pkg::PIN_XIRQ]))
        |=> shared_core_irq)
        else $error("interrupt source did not reach the shared line");

    chk_dedicated_pin: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sync2[P3_B3]) |=> dedicated_pin_irq ##1 dedicated_pin_irq == !$past(sync2[P3_B3]))
        else $error("dedicated line does not follow port 3 bit 3");

    chk_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> (!tick)[*8] ##1 (!tick)[*3] ##1 tick)
        else $error("machine cycle pulse not every twelve clocks");

    chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("APB answer not given in the access phase");

endmodule

// ===== mpaf_pkg.sv
// Package for the MCU port alternate-function block: register map, field positions, reset values.
// Assumes an APB slave with 32-bit data and byte addresses in paddr.
package mpaf_pkg;

    localparam int TMR_W = 26;
    localparam int NUM_TMR = 3;
    localparam int ADDR_W = 8;

    // Register byte offsets.
    localparam logic [7:0] OFF_P1_LATCH  = 8'h00;
    localparam logic [7:0] OFF_P3_LATCH  = 8'h04;
    localparam logic [7:0] OFF_GLOB      = 8'h08;
    localparam logic [7:0] OFF_TCTL      = 8'h0c;
    localparam logic [7:0] OFF_PADS      = 8'h10;
    localparam logic [7:0] OFF_TMR0      = 8'h14;
    localparam logic [7:0] OFF_TMR_STEP  = 8'h04;
    localparam logic [7:0] OFF_T2_CAP    = 8'h20;
    localparam logic [7:0] OFF_T2_RELOAD = 8'h24;
    localparam logic [7:0] OFF_IRQ       = 8'h28;

    // Global control bits.
    localparam int GLOB_W         = 4;
    localparam int GLOB_XIRQ_EN   = 0;
    localparam int GLOB_EXT_MCU   = 1;
    localparam int GLOB_P1_PU_DIS = 2;
    localparam int GLOB_P3_PU_DIS = 3;

    // Timer control fields: three-bit groups are indexed by timer number.
    localparam int TCTL_W      = 11;
    localparam int TCTL_CSEL   = 0;
    localparam int TCTL_RUN    = 3;
    localparam int TCTL_IE     = 6;
    localparam int TCTL_T2TRIG = 9;
    localparam int TCTL_T1GATE = 10;

    // Pad sample vector layout: port 1, port 3, external interrupt pin.
    localparam int PIN_W    = 17;
    localparam int PIN_P1   = 0;
    localparam int PIN_P3   = 8;
    localparam int PIN_XIRQ = 16;

    // Values after reset.
    localparam logic [7:0]        RST_LATCH = 8'hff;
    localparam logic [GLOB_W-1:0] RST_GLOB  = 4'h0;
    localparam logic [TCTL_W-1:0] RST_TCTL  = 11'h000;

    // One machine cycle is twelve MCU clocks.
    localparam int MC_CLOCKS = 12;
    localparam logic [3:0] MC_LAST = 4'(MC_CLOCKS - 1);

    typedef struct packed {
        logic counter_mode;
        logic run;
        logic gate_en;
        logic trig_en;
    } mpaf_tmr_cfg_s;

endpackage

// ===== mpaf_timer.sv
// One timer/counter with optional gate and capture/reload trigger.
// Assumes event, gate and trigger inputs are already synchronised to pclk.
`timescale 1ns/10ps

module mpaf_timer (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire mpaf_pkg::mpaf_tmr_cfg_s       cfg,
    input  wire logic                          tick,
    input  wire logic                          event_fall,
    input  wire logic                          gate_level,
    input  wire logic                          trig_fall,
    input  wire logic                          load_en,
    input  wire logic [mpaf_pkg::TMR_W-1:0]    load_val,
    input  wire logic [mpaf_pkg::TMR_W-1:0]    reload_val,
    output logic      [mpaf_pkg::TMR_W-1:0]    count,
    output logic      [mpaf_pkg::TMR_W-1:0]    capture
);

    logic [mpaf_pkg::TMR_W-1:0] next_count;
    logic [mpaf_pkg::TMR_W-1:0] next_capture;
    logic                       inc;
    logic                       do_reload;
    logic                       do_capture;

    always_comb begin
        // A gated timer only advances while its gate pin is high.
        inc = cfg.run && (!cfg.gate_en || gate_level) &&
              (cfg.counter_mode ? event_fall : tick);
        do_reload  = trig_fall && cfg.trig_en && !cfg.counter_mode;
        do_capture = trig_fall && cfg.trig_en && cfg.counter_mode;
        next_count   = count;
        next_capture = capture;
        if (load_en) begin
            next_count = load_val;
        end else if (do_reload) begin
            next_count = reload_val;
        end else if (inc) begin
            next_count = count + 1'b1;
        end
        if (do_capture) begin
            next_capture = count;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count   <= '0;
            capture <= '0;
        end else begin
            count   <= next_count;
            capture <= next_capture;
        end
    end

    chk_timer_step: assert property (@(posedge pclk) disable iff (!presetn)
        (inc && !load_en && !do_reload) |=> count == $past(count) + 1'b1)
        else $error("timer did not advance by one on its increment cause");

    chk_trig_capture: assert property (@(posedge pclk) disable iff (!presetn)
        do_capture |=> capture == $past(count))
        else $error("trigger in counter mode did not capture the count");

    chk_trig_reload: assert property (@(posedge pclk) disable iff (!presetn)
        (do_reload && !load_en) |=> count == $past(reload_val))
        else $error("trigger in timer mode did not reload the timer");

endmodule

// ===== mpaf_far_side.sv
// Far-side pad model: pull-ups, external pull-down sources and emulator strobes.
// Assumes the bench requests pull-downs through the low masks, one clock domain.
`timescale 1ns/10ps

module mpaf_far_side (
    input  wire logic       pclk,
    input  wire logic [7:0] p1_out,
    input  wire logic [7:0] p1_oe,
    input  wire logic [7:0] p3_out,
    input  wire logic [7:0] p3_oe,
    input  wire logic       p1_pu,
    input  wire logic       p3_pu,
    input  wire logic [7:0] p1_lo,
    input  wire logic [7:0] p3_lo,
    output logic      [7:0] p1_in,
    output logic      [7:0] p3_in
);
    logic [7:0] last1 = 8'h00;
    logic [7:0] last3 = 8'h00;

    // An undriven pad without pull-up shows no stable value, so it toggles.
    assign p1_in = (p1_oe & p1_out) | (~p1_oe & ~p1_lo & ({8{p1_pu}} | ~last1));
    // Emulator strobes arrive as pull-downs on bits 7 and 6.
    assign p3_in = (p3_oe & p3_out) | (~p3_oe & ~p3_lo & ({8{p3_pu}} | ~last3));

    always @(posedge pclk) begin
        last1 <= p1_in;
        last3 <= p3_in;
    end
endmodule

// ===== mpaf_port_mux_bench.sv
// Self-checking bench for the port alternate-function block.
// Assumes the far-side pad model and a 25 MHz clock.
`timescale 1ns/10ps

module mpaf_port_mux_bench;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00, p1_lo = 8'h00, p3_lo = 8'h00;
    logic [7:0]  p1_in, p3_in, p1_out, p1_oe, p3_out, p3_oe;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r, a0, a1;
    logic        pready, pslverr, e, p1_pullup_en, p3_pullup_en;
    logic        external_irq_in_n = 1'h1, internal_irq_src = 1'h0;
    logic        core_rd_strobe_n = 1'h1, core_wr_strobe_n = 1'h1;
    logic        shared_core_irq, dedicated_pin_irq, mem_rd_strobe_n, mem_wr_strobe_n;
    int          bad_count = 0, n_checks = 0;

    mpaf_port_mux i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .p1_in, .p3_in, .p1_out, .p1_oe, .p3_out, .p3_oe,
        .p1_pullup_en, .p3_pullup_en, .external_irq_in_n, .internal_irq_src,
        .core_rd_strobe_n, .core_wr_strobe_n, .shared_core_irq, .dedicated_pin_irq,
        .mem_rd_strobe_n, .mem_wr_strobe_n);
    mpaf_far_side i_far (.pclk, .p1_out, .p1_oe, .p3_out, .p3_oe, .p1_pu(p1_pullup_en),
        .p3_pu(p3_pullup_en), .p1_lo, .p3_lo, .p1_in, .p3_in);

    initial begin
        forever #20 pclk = ~pclk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask

    // Request is held until pready is sampled high; data taken at that edge.
    // One idle edge follows, so that a second call never re-drives psel in the same step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    // Each level is held thirteen clocks so that every fall is counted.
    task automatic pulse(input logic on_p1, input int b);
        if (on_p1) p1_lo[b] <= 1'h1; else p3_lo[b] <= 1'h1;
        cyc(13);
        if (on_p1) p1_lo[b] <= 1'h0; else p3_lo[b] <= 1'h0;
        cyc(13);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        cyc(20000);
        bad_count++;
        summarize();
    end

    initial begin
        cyc(8);
        presetn <= 1'h1;
        cyc(1);
        chk("pins", 32'hffff_0000, {p1_out, p3_out, p1_oe, p3_oe});
        chk("pullups", 32'h0000_0003, {30'h0, p1_pullup_en, p3_pullup_en});
        apb(1'h1, 8'h04, 32'h0000_0000);
        apb(1'h1, 8'h00, 32'h0000_005a);
        cyc(2);
        chk("p3_out", 32'h0000_00c0, {24'h0, p3_out});
        chk("p3_oe", 32'h0000_003f, {24'h0, p3_oe});
        chk("p1_out", 32'h0000_005a, {24'h0, p1_out});
        apb(1'h1, 8'h04, 32'h0000_00ff);
        do @(posedge pclk); while (p3_out[0] !== 1'h1);
        chk("oe c0", 32'h0000_0001, {31'h0, p3_oe[0]});
        cyc(1);
        chk("oe c1", 32'h0000_0001, {31'h0, p3_oe[0]});
        cyc(1);
        chk("oe c2", 32'h0000_0000, {31'h0, p3_oe[0]});
        apb(1'h1, 8'h00, 32'h0000_00ff);
        apb(1'h0, 8'h2c, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, e});
        p3_lo[3] <= 1'h1;
        external_irq_in_n <= 1'h0;
        cyc(5);
        chk("irq p33", 32'h0000_0001, {30'h0, shared_core_irq, dedicated_pin_irq});
        apb(1'h1, 8'h08, 32'h0000_0001);
        cyc(5);
        chk("irq xen", 32'h0000_0003, {30'h0, shared_core_irq, dedicated_pin_irq});
        apb(1'h1, 8'h08, 32'h0000_0000);
        p3_lo[3] <= 1'h0;
        internal_irq_src <= 1'h1;
        cyc(5);
        chk("irq int", 32'h0000_0002, {30'h0, shared_core_irq, dedicated_pin_irq});
        internal_irq_src <= 1'h0;
        p3_lo[2] <= 1'h1;
        cyc(5);
        chk("irq p32", 32'h0000_0002, {30'h0, shared_core_irq, dedicated_pin_irq});
        p3_lo[2] <= 1'h0;
        p3_lo[3] <= 1'h1;
        apb(1'h1, 8'h0c, 32'h0000_0418);
        apb(1'h0, 8'h14, 32'h0000_0000);
        a0 = r;
        apb(1'h0, 8'h18, 32'h0000_0000);
        a1 = r;
        cyc(114);
        apb(1'h0, 8'h14, 32'h0000_0000);
        chk("t0 ticks", 32'd10, r - a0);
        apb(1'h0, 8'h18, 32'h0000_0000);
        chk("t1 gated", 32'd0, r - a1);
        p3_lo[3] <= 1'h0;
        apb(1'h1, 8'h0c, 32'h0000_023f);
        apb(1'h1, 8'h14, 32'h0000_0000);
        apb(1'h1, 8'h18, 32'h0000_0000);
        apb(1'h1, 8'h1c, 32'h0000_0000);
        for (int i = 0; i < 3; i++) pulse(1'h0, 5);
        pulse(1'h0, 4);
        for (int i = 0; i < 2; i++) pulse(1'h1, 0);
        pulse(1'h1, 1);
        apb(1'h0, 8'h18, 32'h0000_0000);
        chk("t1 events", 32'd3, r);
        apb(1'h0, 8'h14, 32'h0000_0000);
        chk("t0 events", 32'd1, r);
        apb(1'h0, 8'h20, 32'h0000_0000);
        chk("t2 capture", 32'd2, r);
        apb(1'h1, 8'h0c, 32'h0000_0282);
        apb(1'h0, 8'h10, 32'h0000_0000);
        chk("pads", 32'h1bfd_ffff, r);
        core_rd_strobe_n <= 1'h0;
        cyc(2);
        chk("rd int", 32'h0000_0000, {30'h0, mem_rd_strobe_n, p3_out[7]});
        core_rd_strobe_n <= 1'h1;
        core_wr_strobe_n <= 1'h0;
        cyc(2);
        chk("wr int", 32'h0000_0000, {30'h0, mem_wr_strobe_n, p3_out[6]});
        core_wr_strobe_n <= 1'h1;
        p3_lo[7] <= 1'h1;
        apb(1'h1, 8'h08, 32'h0000_0002);
        cyc(5);
        chk("emu", 32'h0000_0003, {29'h0, mem_rd_strobe_n, mem_wr_strobe_n, p3_out[7]});
        p3_lo[7] <= 1'h0;
        apb(1'h1, 8'h08, 32'h0000_000c);
        cyc(2);
        chk("pu off", 32'h0000_0000, {30'h0, p1_pullup_en, p3_pullup_en});
        summarize();
    end
endmodule
